// ### rtl/vamp_ctrl_pkg.sv
// Purpose: shared constants for the video amplifier control target
// Assumes: 7-bit target addressing, one register per channel
// Notes:   field positions and codes of the channel register
package vamp_ctrl_pkg;
	localparam logic [4:0] ADDR_FIXED       = 5'h0b;
	localparam int         NUM_CHANNELS     = 3;
	localparam int         REG_WIDTH        = 8;
	localparam int         FILT_HI          = 7;
	localparam int         FILT_LO          = 6;
	localparam int         MUX_BIT          = 5;
	localparam int         MODE_HI          = 2;
	localparam int         MODE_LO          = 0;
	localparam logic [7:0] SUB_CH1          = 8'h01;
	localparam logic [7:0] SUB_CH3          = 8'h03;
	localparam logic [1:0] FILT_500K        = 2'h0;
	localparam logic [1:0] FILT_2M5         = 2'h1;
	localparam logic [1:0] FILT_5M          = 2'h2;
	localparam logic [2:0] MODE_OFF         = 3'h0;
	localparam logic [2:0] MODE_MUTE        = 3'h1;
	localparam logic [2:0] MODE_DC          = 3'h2;
	localparam logic [2:0] MODE_DC_OFS      = 3'h3;
	localparam logic [2:0] MODE_AC          = 3'h4;
	localparam logic [2:0] MODE_CLAMP_LOW   = 3'h5;
	localparam logic [2:0] MODE_CLAMP_MID   = 3'h6;
	localparam logic [2:0] MODE_CLAMP_HIGH  = 3'h7;
	localparam logic [2:0] BIAS_NONE        = 3'h0;
	localparam logic [3:0] BIT_LAST         = 4'h7;
	localparam logic [2:0] CH_RESET_VALUE   = 3'h0;
	localparam logic [7:0] CFG_RESET_VALUE  = 8'h00;
endpackage

// ### rtl/chan_decode.sv
// Purpose: decode one channel register into analog control levels
// Assumes: register value comes from the same clock domain
// Notes:   outputs are registered
`timescale 1ns/1ns
module chan_decode
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [7:0] cfg,
	output logic            enable,
	output logic            mute,
	output logic            mux_b,
	output logic            dc_bias,
	output logic            dc_offset,
	output logic            ac_bias,
	output logic            clamp_on,
	output logic [2:0]      sink_level,
	output logic [1:0]      clamp_filt
);
	logic [2:0] mode;
	logic [1:0] fsel;
	logic [11:0] dec_nxt;
	logic [11:0] dec_r;

	assign mode = cfg[vamp_ctrl_pkg::MODE_HI:vamp_ctrl_pkg::MODE_LO];
	assign fsel = cfg[vamp_ctrl_pkg::FILT_HI:vamp_ctrl_pkg::FILT_LO];

	always_comb
	begin
		dec_nxt = '0;
		// bits 4 and 3 never looked at
		dec_nxt[0] = (mode != vamp_ctrl_pkg::MODE_OFF);
		dec_nxt[1] = (mode == vamp_ctrl_pkg::MODE_MUTE);
		dec_nxt[2] = cfg[vamp_ctrl_pkg::MUX_BIT];
		dec_nxt[3] = (mode == vamp_ctrl_pkg::MODE_DC);
		dec_nxt[4] = (mode == vamp_ctrl_pkg::MODE_DC_OFS);
		dec_nxt[5] = (mode == vamp_ctrl_pkg::MODE_AC);
		unique case (mode)
			vamp_ctrl_pkg::MODE_CLAMP_LOW:  dec_nxt[9:6] = 4'h3;
			vamp_ctrl_pkg::MODE_CLAMP_MID:  dec_nxt[9:6] = 4'h5;
			vamp_ctrl_pkg::MODE_CLAMP_HIGH: dec_nxt[9:6] = 4'h9;
			default:                        dec_nxt[9:6] = 4'h0;
		endcase
		// filter select only meaningful in clamp modes
		if (dec_nxt[6])
		begin
			unique case (fsel)
				2'h0:    dec_nxt[11:10] = vamp_ctrl_pkg::FILT_500K;
				2'h1:    dec_nxt[11:10] = vamp_ctrl_pkg::FILT_2M5;
				default: dec_nxt[11:10] = vamp_ctrl_pkg::FILT_5M;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dec_r <= '0;
		else
			dec_r <= dec_nxt;
	end

	assign enable     = dec_r[0];
	assign mute       = dec_r[1];
	assign mux_b      = dec_r[2];
	assign dc_bias    = dec_r[3];
	assign dc_offset  = dec_r[4];
	assign ac_bias    = dec_r[5];
	assign clamp_on   = dec_r[6];
	assign sink_level = dec_r[9:7];
	assign clamp_filt = dec_r[11:10];
endmodule

// ### rtl/vamp_i2c_target.sv
// Purpose: i2c target holding three channel configuration registers
// Assumes: SCL and SDA oversampled by CLK (20 MHz) after two flops
// Notes:   SDA is open drain: SDA_OE high pulls the line low
//
// Behaviour
// - bits 7:6 pick clamp filter 500k/2.5M/5M
// - filter select ignored outside clamp modes
// - bit 5 selects input A or B
// - bits 4:3 reserved, no effect
// - low bits: off, mute, dc, dc+offset, ac
// - codes 101-111 clamp low/mid/high sink
// - each channel has its own register
// - write: addr+0, subaddress, data, all acked
// - ack subaddress and data after full byte
// - one data byte per transaction only
// - address bits 2:1 compared to live pins
// - read: addr+1, ack, return selected register
// - all bytes shifted msb first
// - fixed address prefix 01011
// - subaddresses 1,2,3 map to channels 1-3
// - stuck ack released by one SCL cycle
`timescale 1ns/1ns
module vamp_i2c_target
(
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	input  wire logic       ADDR_SEL_HI,
	input  wire logic       ADDR_SEL_LO,
	output logic [2:0]      CH_ENABLE,
	output logic [2:0]      CH_MUTE,
	output logic [2:0]      CH_MUX_B,
	output logic [2:0]      CH_DC_BIAS,
	output logic [2:0]      CH_DC_OFFSET,
	output logic [2:0]      CH_AC_BIAS,
	output logic [2:0]      CH_CLAMP_ON,
	output logic [8:0]      CH_SINK_LEVEL,
	output logic [5:0]      CH_CLAMP_FILT
);
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_SUB  = 3'b010,
		ST_DATA = 3'b011,
		ST_READ = 3'b100,
		ST_DONE = 3'b101
	} state_t;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] scl_s_r;
	logic [1:0] sda_s_r;
	logic [1:0] asel_s_r;
	logic [1:0] asel_m_r;
	logic       scl_d_r;
	logic       sda_d_r;

	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			scl_s_r  <= 2'h3;
			sda_s_r  <= 2'h3;
			asel_m_r <= 2'h0;
			asel_s_r <= 2'h0;
			scl_d_r  <= 1'b1;
			sda_d_r  <= 1'b1;
		end
		else
		begin
			scl_s_r  <= {scl_s_r[0], SCL};
			sda_s_r  <= {sda_s_r[0], SDA_IN};
			// address pins are resampled every clock, never latched
			asel_m_r <= {ADDR_SEL_HI, ADDR_SEL_LO};
			asel_s_r <= asel_m_r;
			scl_d_r  <= scl_s_r[1];
			sda_d_r  <= sda_s_r[1];
		end
	end

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;

	assign scl       = scl_s_r[1];
	assign sda       = sda_s_r[1];
	assign scl_rise  = scl & ~scl_d_r;
	assign scl_fall  = ~scl & scl_d_r;
	assign start_det = scl & scl_d_r & sda_d_r & ~sda;
	assign stop_det  = scl & scl_d_r & ~sda_d_r & sda;

	// ------------------------------------------------------------
	// protocol engine
	// ------------------------------------------------------------
	state_t     state_r;
	state_t     state_nxt;
	logic [3:0] bit_r;
	logic [3:0] bit_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic       ack_phase_r;
	logic       ack_phase_nxt;
	logic       drive_r;
	logic       drive_nxt;
	logic       sda_oe_r;
	logic       sda_oe_nxt;
	logic [1:0] sub_r;
	logic [1:0] sub_nxt;
	logic       sub_ok_r;
	logic       sub_ok_nxt;
	logic [7:0] cfg_r [vamp_ctrl_pkg::NUM_CHANNELS];
	logic [7:0] cfg_nxt [vamp_ctrl_pkg::NUM_CHANNELS];

	function automatic logic [7:0] read_value(input logic [1:0] sel, input logic ok,
		input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
		logic [7:0] v;
		v = 8'h00;
		if (ok)
		begin
			unique case (sel)
				2'h1:    v = c0;
				2'h2:    v = c1;
				default: v = c2;
			endcase
		end
		return v;
	endfunction

	always_comb
	begin
		state_nxt     = state_r;
		bit_nxt       = bit_r;
		shift_nxt     = shift_r;
		ack_phase_nxt = ack_phase_r;
		drive_nxt     = drive_r;
		sda_oe_nxt    = sda_oe_r;
		sub_nxt       = sub_r;
		sub_ok_nxt    = sub_ok_r;
		for (int i = 0; i < vamp_ctrl_pkg::NUM_CHANNELS; i++)
			cfg_nxt[i] = cfg_r[i];

		if (start_det)
		begin
			state_nxt     = ST_ADDR;
			bit_nxt       = 4'h0;
			ack_phase_nxt = 1'b0;
			sda_oe_nxt    = 1'b0;
			drive_nxt     = 1'b0;
		end
		else if (stop_det)
		begin
			// a stop inside an ack slot must not leave a read pending
			state_nxt     = ST_IDLE;
			sda_oe_nxt    = 1'b0;
			ack_phase_nxt = 1'b0;
			drive_nxt     = 1'b0;
		end
		else if (scl_rise && !ack_phase_r && state_r != ST_IDLE && state_r != ST_DONE)
		begin
			if (state_r == ST_READ && bit_r == 4'h8)
			begin
				// host ack slot of the read byte: nack or ack, no second byte follows
				state_nxt = ST_DONE;
			end
			else
			begin
				shift_nxt = {shift_r[6:0], sda};
				bit_nxt   = bit_r + 4'h1;
			end
		end
		else if (scl_fall)
		begin
			if (ack_phase_r)
			begin
				// release after the ack clock; also clears a stuck ack
				ack_phase_nxt = 1'b0;
				sda_oe_nxt    = 1'b0;
				bit_nxt       = 4'h0;
				if (drive_r)
				begin
					shift_nxt  = read_value(sub_r, sub_ok_r, cfg_r[0], cfg_r[1], cfg_r[2]);
					sda_oe_nxt = ~shift_nxt[7];
					state_nxt  = ST_READ;
					drive_nxt  = 1'b0;
				end
			end
			else if (state_r == ST_READ)
			begin
				// after the eighth bit the line belongs to the host for its ack
				if (bit_r != 4'h8)
					sda_oe_nxt = ~shift_r[7];
				else
					sda_oe_nxt = 1'b0;
			end
			else if (bit_r == 4'h8)
			begin
				bit_nxt = 4'h0;
				unique case (state_r)
					ST_ADDR:
					begin
						if (shift_r[7:3] == vamp_ctrl_pkg::ADDR_FIXED && shift_r[2:1] == asel_s_r)
						begin
							ack_phase_nxt = 1'b1;
							sda_oe_nxt    = 1'b1;
							drive_nxt     = shift_r[0];
							state_nxt     = shift_r[0] ? ST_READ : ST_SUB;
						end
						else
							state_nxt = ST_IDLE;
					end
					ST_SUB:
					begin
						ack_phase_nxt = 1'b1;
						sda_oe_nxt    = 1'b1;
						sub_nxt       = shift_r[1:0];
						sub_ok_nxt    = shift_r >= vamp_ctrl_pkg::SUB_CH1 && shift_r <= vamp_ctrl_pkg::SUB_CH3;
						state_nxt     = ST_DATA;
					end
					ST_DATA:
					begin
						ack_phase_nxt = 1'b1;
						sda_oe_nxt    = 1'b1;
						state_nxt     = ST_DONE;
						for (int i = 0; i < vamp_ctrl_pkg::NUM_CHANNELS; i++)
							if (sub_ok_r && sub_r == 2'(i + 1))
								cfg_nxt[i] = shift_r;
					end
					default:
						state_nxt = ST_IDLE;
				endcase
			end
		end
	end

	// shift register reload on a read byte happens on the falling edges
	always_ff @(posedge CLK or posedge RST)
	begin
		if (RST)
		begin
			state_r     <= ST_IDLE;
			bit_r       <= 4'h0;
			shift_r     <= 8'h00;
			ack_phase_r <= 1'b0;
			drive_r     <= 1'b0;
			sda_oe_r    <= 1'b0;
			sub_r       <= 2'h0;
			sub_ok_r    <= 1'b0;
			for (int i = 0; i < vamp_ctrl_pkg::NUM_CHANNELS; i++)
				cfg_r[i] <= vamp_ctrl_pkg::CFG_RESET_VALUE;
		end
		else
		begin
			state_r     <= state_nxt;
			bit_r       <= bit_nxt;
			shift_r     <= shift_nxt;
			ack_phase_r <= ack_phase_nxt;
			drive_r     <= drive_nxt;
			sda_oe_r    <= sda_oe_nxt;
			sub_r       <= sub_nxt;
			sub_ok_r    <= sub_ok_nxt;
			for (int i = 0; i < vamp_ctrl_pkg::NUM_CHANNELS; i++)
				cfg_r[i] <= cfg_nxt[i];
		end
	end

	assign SDA_OE  = sda_oe_r;
	// open drain: the pad only ever pulls low, the pull-up makes the ones
	assign SDA_OUT = 1'b0;

	// ------------------------------------------------------------
	// per-channel decode
	// ------------------------------------------------------------
	for (genvar g = 0; g < vamp_ctrl_pkg::NUM_CHANNELS; g++)
	begin : g_ch
		chan_decode u_dec
		(
			.clk        (CLK),
			.rst        (RST),
			.cfg        (cfg_r[g]),
			.enable     (CH_ENABLE[g]),
			.mute       (CH_MUTE[g]),
			.mux_b      (CH_MUX_B[g]),
			.dc_bias    (CH_DC_BIAS[g]),
			.dc_offset  (CH_DC_OFFSET[g]),
			.ac_bias    (CH_AC_BIAS[g]),
			.clamp_on   (CH_CLAMP_ON[g]),
			.sink_level (CH_SINK_LEVEL[3*g +: 3]),
			.clamp_filt (CH_CLAMP_FILT[2*g +: 2])
		);
	end
endmodule

// ### dv/vamp_i2c_target_properties.sv
// Purpose: port checks of the channel decode and sda drive
// Assumes: CH_* are registered levels
// Notes:   bound to every target instance
`timescale 1ns/1ns
module vamp_i2c_target_properties
(
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       SCL,
	input wire logic       SDA_IN,
	input wire logic       SDA_OUT,
	input wire logic       SDA_OE,
	input wire logic       ADDR_SEL_HI,
	input wire logic       ADDR_SEL_LO,
	input wire logic [2:0] CH_ENABLE,
	input wire logic [2:0] CH_MUTE,
	input wire logic [2:0] CH_MUX_B,
	input wire logic [2:0] CH_DC_BIAS,
	input wire logic [2:0] CH_DC_OFFSET,
	input wire logic [2:0] CH_AC_BIAS,
	input wire logic [2:0] CH_CLAMP_ON,
	input wire logic [8:0] CH_SINK_LEVEL,
	input wire logic [5:0] CH_CLAMP_FILT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	a_mute_needs_on: assert property ((CH_MUTE & ~CH_ENABLE) == 3'h0) else $error("mute while off");
	a_bias_excl: assert property ((CH_DC_BIAS & (CH_DC_OFFSET | CH_AC_BIAS | CH_CLAMP_ON)) == 3'h0)
		else $error("two bias modes");
	a_clamp_needs_on: assert property ((CH_CLAMP_ON & ~CH_ENABLE) == 3'h0) else $error("clamp while off");
	a_sink_hot: assert property (CH_CLAMP_ON[0] == (|CH_SINK_LEVEL[2:0]) && $onehot0(CH_SINK_LEVEL[2:0]))
		else $error("sink level");
	a_filt_idle: assert property (!CH_CLAMP_ON[1] |-> CH_CLAMP_FILT[3:2] == 2'h0) else $error("filter outside clamp");
	a_filt_code: assert property (CH_CLAMP_FILT[5:4] != 2'h3) else $error("filter code");
	a_sda_open: assert property (SDA_OUT == 1'b0) else $error("sda driven high");
	a_ack_steady: assert property (SCL [*4] |-> $stable(SDA_OE)) else $error("sda moved in scl high");
	a_reset_quiet: assert property ($past(RST) |-> CH_ENABLE == 3'h0 && !SDA_OE) else $error("not idle");
	a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL) else $error("sda moved while scl high");
	c_ack: cover property ($rose(SDA_OE));
	c_clamp: cover property (CH_CLAMP_ON[1]);
	c_mux: cover property (CH_MUX_B[2]);
endmodule
bind vamp_i2c_target vamp_i2c_target_properties u_props (.*);

// ### dv/i2c_host_model.sv
// Purpose: i2c bus controller model
// Assumes: SDA pulled up; a released line reads 1
// Notes:   h is the half period in CLK cycles; raise it for a slow host
`timescale 1ns/1ns
module i2c_host_model
(
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	int h = 4;
	initial
	begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// scl stands high between frames
	task automatic start();
		wt(1);
		sda_drv <= 1'b1;
		wt(h);
		scl <= 1'b1;
		wt(h);
		sda_drv <= 1'b0;
		wt(h);
		scl <= 1'b0;
	endtask
	task automatic stop();
		wt(1);
		sda_drv <= 1'b0;
		wt(h);
		scl <= 1'b1;
		wt(h);
		sda_drv <= 1'b1;
		wt(h);
	endtask
	// data moves one clock after scl falls, never while high
	task automatic bit_io(input logic b, output logic r);
		wt(1);
		sda_drv <= b;
		wt(h - 1);
		scl <= 1'b1;
		wt(h);
		r = sda_line;
		scl <= 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(1'b1, k);
	endtask
endmodule

// ### dv/tb_top.sv
// Purpose: self-checking bench of the channel control target
// Assumes: registers clear on reset
// Notes:   host model is the bus controller
`timescale 1ns/1ns
module tb_top;
	logic       CLK, RST, ADDR_SEL_HI, ADDR_SEL_LO, SCL, SDA_OUT, SDA_OE, sda_drv, k;
	logic [2:0] CH_ENABLE, CH_MUTE, CH_MUX_B, CH_DC_BIAS, CH_DC_OFFSET, CH_AC_BIAS, CH_CLAMP_ON;
	logic [8:0] CH_SINK_LEVEL;
	logic [5:0] CH_CLAMP_FILT;
	logic [7:0] shadow[3], d, q;
	int         fail_count, comparisons, ch;
	wire        SDA_IN = sda_drv & ~SDA_OE;
	vamp_i2c_target u_vamp_i2c_target (.*);
	i2c_host_model u_i2c_host_model (.clk(CLK), .sda_line(SDA_IN), .scl(SCL), .sda_drv(sda_drv));
	initial
	begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	task automatic check(input logic [11:0] a, input logic [11:0] e, input string m);
		comparisons++;
		if (a !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	function automatic logic [11:0] dec(input logic [7:0] c);
		logic [2:0] m;
		logic       cl;
		m = c[2:0];
		cl = m > 3'h4;
		dec = {m != 3'h0, m == 3'h1, c[5], m == 3'h2, m == 3'h3, m == 3'h4, cl,
			cl ? 3'h1 << (m - 3'h5) : 3'h0, cl ? (c[7] ? 2'h2 : {1'b0, c[6]}) : 2'h0};
	endfunction
	task automatic check_all();
		for (int g = 0; g < 3; g++)
			check({CH_ENABLE[g], CH_MUTE[g], CH_MUX_B[g], CH_DC_BIAS[g], CH_DC_OFFSET[g], CH_AC_BIAS[g],
				CH_CLAMP_ON[g], CH_SINK_LEVEL[3*g+:3], CH_CLAMP_FILT[2*g+:2]}, dec(shadow[g]), "decode");
	endtask
	function automatic logic [7:0] ad(input logic r);
		ad = {5'h0b, ADDR_SEL_HI, ADDR_SEL_LO, r};
	endfunction
	task automatic xb(input logic [7:0] b, input logic e, input string m);
		u_i2c_host_model.byte_io(b, q, k);
		check(12'(k), 12'(e), m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] s, input logic [7:0] v, input logic e);
		u_i2c_host_model.start();
		xb(a, e, "addr ack");
		if (!e)
		begin
			xb(s, 1'b0, "sub ack");
			xb(v, 1'b0, "data ack");
		end
		u_i2c_host_model.stop();
	endtask
	task automatic rd(input logic [7:0] s, input logic [7:0] e);
		u_i2c_host_model.start();
		xb(ad(1'b0), 1'b0, "rd set addr ack");
		xb(s, 1'b0, "rd set sub ack");
		u_i2c_host_model.stop();
		u_i2c_host_model.start();
		xb(ad(1'b1), 1'b0, "rd addr ack");
		xb(8'hff, 1'b1, "rd nack");
		check(12'(q), 12'(e), "rd data");
		u_i2c_host_model.stop();
	endtask
	task automatic final_report();
		$display("checks %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		repeat (100000) @(posedge CLK);
		fail_count++;
		$display("[FAIL] %0t run too long", $time);
		final_report();
	end
	initial
	begin
		RST = 1'b1;
		ADDR_SEL_HI = 1'b0;
		ADDR_SEL_LO = 1'b0;
		shadow = '{3{8'h00}};
		void'($urandom(32'h7e55cb10));
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		repeat (6) @(posedge CLK);
		check_all();
		for (int i = 0; i < 16; i++)
		begin
			ch = int'($urandom % 3);
			d = (i == 8) ? 8'hf5 : {8'($urandom) & 8'hf8} | 8'(i % 8);
			u_i2c_host_model.h = (i > 11) ? 6 : 4;
			ADDR_SEL_HI <= 1'($urandom);
			ADDR_SEL_LO <= 1'($urandom);
			@(posedge CLK);
			wr(ad(1'b0), 8'(ch + 1), d, 1'b0);
			shadow[ch] = d;
			check_all();
			rd(8'(ch + 1), d);
		end
		$display("test modes done");
		wr({5'h0b, ~ADDR_SEL_HI, ADDR_SEL_LO, 1'b0}, 8'h01, 8'h00, 1'b1);
		wr(ad(1'b0), 8'h00, 8'hff, 1'b0);
		check_all();
		rd(8'h00, 8'h00);
		$display("test refusals done");
		u_i2c_host_model.start();
		xb(ad(1'b0), 1'b0, "x addr");
		xb(8'h02, 1'b0, "x sub");
		xb(8'h11, 1'b0, "x data");
		xb(8'h22, 1'b1, "extra byte");
		u_i2c_host_model.stop();
		shadow[1] = 8'h11;
		u_i2c_host_model.start();
		xb(ad(1'b0), 1'b0, "a addr");
		xb(8'h03, 1'b0, "a sub");
		for (int i = 0; i < 4; i++)
			u_i2c_host_model.bit_io(1'b1, k);
		u_i2c_host_model.stop();
		check_all();
		$display("test extra and abort done");
		final_report();
	end
endmodule
